/* File: rtl/can_mode_pkg.sv */
`default_nettype none
package can_mode_pkg;
  // operating modes of the transceiver
  typedef enum logic [1:0] {
    MODE_SLEEP   = 2'b00,
    MODE_TXRX    = 2'b01,
    MODE_RXONLY  = 2'b10
  } can_mode_t;

  // slew settings, fastest is the reset value
  localparam logic [1:0] SLEW_FAST    = 2'h0;
  localparam logic [1:0] SLEW_MEDIUM  = 2'h1;
  localparam logic [1:0] SLEW_SLOW    = 2'h2;

  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  // valid dominant pulse: longer than 500 ns (least time, round up)
  localparam int unsigned PULSE_MIN_NS  = 500;
  localparam int unsigned PULSE_MIN_CYC =
    (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // single pulse wake: 2.0 us typical, taken as least time
  localparam int unsigned SINGLE_NS     = 2000;
  localparam int unsigned SINGLE_CYC    =
    (SINGLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // pattern window: 120 us (longest time, round down)
  localparam int unsigned WINDOW_US     = 120;
  localparam int unsigned WINDOW_CYC    = (WINDOW_US * 1000000) / CLK_PERIOD_PS;
  localparam logic [1:0]  PATTERN_COUNT = 2'h3;
  // controller-side limit: 12 dominant bits under 300 us
  localparam int unsigned DOM_BITS_MAX  = 12;
  localparam int unsigned DOM_TMO_US    = 300;
endpackage
`default_nettype wire

/* File: rtl/wake_if.sv */
`default_nettype none
interface wake_if;
  logic bus_dom;
  logic arm;
  logic single_sel;
  logic wake;
  modport detector (input bus_dom, input arm, input single_sel, output wake);
  modport ctrl     (output bus_dom, output arm, output single_sel, input wake);
endinterface
`default_nettype wire

/* File: rtl/can_wake_detect.sv */
`default_nettype none
module can_wake_detect #(
  parameter int unsigned WIN_CYC = can_mode_pkg::WINDOW_CYC
) (
  input  wire logic     ref_clk_in,
  input  wire logic     reset_in,
  wake_if.detector      wk
);
  // ******************************
  // pulse length and window timers
  // ******************************
  logic [6:0]  plen_q;
  logic [6:0]  plen_d;
  logic [12:0] win_q;
  logic [12:0] win_d;
  logic [1:0]  cnt_q;
  logic [1:0]  cnt_d;
  logic        dom_q;
  logic        wake_q;

  wire fall      = dom_q && !wk.bus_dom;
  wire valid_end = fall && (plen_q >= 7'(can_mode_pkg::PULSE_MIN_CYC));
  wire win_exp   = (cnt_q != 2'h0) && (win_q == 13'(WIN_CYC));
  // fires once per long pulse so the interrupt stays a single-cycle pulse
  wire single_ok = wk.single_sel && wk.bus_dom &&
                   (plen_q == 7'(can_mode_pkg::SINGLE_CYC - 1));
  wire pat_ok    = !wk.single_sel && valid_end &&
                   (cnt_q == can_mode_pkg::PATTERN_COUNT - 2'h1) && !win_exp;

  assign plen_d = !wk.bus_dom ? 7'h00 : (plen_q == 7'h7F ? plen_q : plen_q + 7'h01);
  // short pulses neither advance nor clear the count
  assign cnt_d  = (!wk.arm || win_exp || pat_ok) ? 2'h0 :
                  (valid_end && !wk.single_sel) ? cnt_q + 2'h1 : cnt_q;
  // window starts at first valid pulse end
  assign win_d  = (cnt_d == 2'h0) ? 13'h0000 : win_q + 13'h0001;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      plen_q <= 7'h00;
      win_q  <= 13'h0000;
      cnt_q  <= 2'h0;
      dom_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      plen_q <= plen_d;
      win_q  <= win_d;
      cnt_q  <= cnt_d;
      dom_q  <= wk.bus_dom;
      wake_q <= wk.arm && (pat_ok || single_ok);
    end
  end
  assign wk.wake = wake_q;

  count_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    win_exp |=> cnt_q == 2'h0) else $error("window expiry kept count");
  short_ignored_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (wk.arm && !win_exp && fall && plen_q < 7'(can_mode_pkg::PULSE_MIN_CYC))
    |=> $stable(cnt_q)) else $error("short pulse changed count");
  cov_pattern: cover property (@(posedge ref_clk_in) pat_ok);
  cov_single:  cover property (@(posedge ref_clk_in) single_ok && wk.arm);
endmodule
`default_nettype wire

/* File: rtl/can_mode_wake.sv */
`default_nettype none
// Operation
// - tx/rx mode: driver and receiver active
// - receive-only: driver off, tx pin ignored
// - active modes need bus regulator on
// - driver enables in normal with tx high
// - tx low dominant, tx high recessive
// - awake: rx low when dominant, high when recessive; rx held high in sleep
// - split active when awake, floating in sleep
// - three slew settings, fastest by default
// - sleep: drivers off, terminations grounded
// - wake detection enabled by setting
// - wake sets flags, pulses interrupt, wakes if low power mode
// - pattern: three pulses over 500 ns, 120 us
// - single-pulse select: one 2 us pulse
// - leaving sleep returns lines recessive first
module can_mode_wake #(
  parameter int unsigned WIN_CYC = can_mode_pkg::WINDOW_CYC
) (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic [1:0] mode_sel_in,
  input  wire logic       normal_mode_in,
  input  wire logic       low_power_mode_in,
  input  wire logic       bus_reg_on_in,
  input  wire logic [1:0] slew_sel_in,
  input  wire logic       slew_wr_in,
  input  wire logic       wake_en_in,
  input  wire logic       single_pulse_wake_select_in,
  input  wire logic       wake_flag_clr_in,
  input  wire logic       tx_pin_in,
  input  wire logic       bus_diff_dom_in,
  output logic            rx_pin_out,
  output logic            drv_en_out,
  output logic            drv_dominant_out,
  output logic            rcv_en_out,
  output logic            split_en_out,
  output logic            term_gnd_out,
  output logic            wake_rcv_en_out,
  output logic [1:0]      slew_out,
  output logic            wake_flag_out,
  output logic            int_pulse_out,
  output logic            wake_req_out,
  output logic [1:0]      mode_out
);
  // ******************************
  // pin synchronisers
  // ******************************
  logic [2:0] tx_sync_q;
  logic [2:0] bus_sync_q;
  logic       tx_q;
  logic       bus_dom_q;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_sync_q  <= 3'h7;
      bus_sync_q <= 3'h0;
      tx_q       <= 1'b1;
      bus_dom_q  <= 1'b0;
    end else begin
      tx_sync_q  <= {tx_sync_q[1:0], tx_pin_in};
      bus_sync_q <= {bus_sync_q[1:0], bus_diff_dom_in};
      if (tx_sync_q[1] == tx_sync_q[2]) tx_q <= tx_sync_q[2];
      if (bus_sync_q[1] == bus_sync_q[2]) bus_dom_q <= bus_sync_q[2];
    end
  end

  // ******************************
  // mode decode
  // ******************************
  can_mode_pkg::can_mode_t mode_q;
  can_mode_pkg::can_mode_t mode_d;
  logic       drv_en_q;
  logic       drv_en_d;
  logic [1:0] slew_q;
  logic       wake_flag_q;
  logic       int_q;
  logic       wake_req_q;

  // awake modes fall back to sleep without the bus regulator
  wire req_txrx   = mode_sel_in == can_mode_pkg::MODE_TXRX;
  wire req_rxonly = mode_sel_in == can_mode_pkg::MODE_RXONLY;
  wire awake_ok   = bus_reg_on_in && !low_power_mode_in;
  assign mode_d   = !awake_ok ? can_mode_pkg::MODE_SLEEP :
                    req_txrx ? can_mode_pkg::MODE_TXRX :
                    req_rxonly ? can_mode_pkg::MODE_RXONLY : can_mode_pkg::MODE_SLEEP;
  // driver follows the next mode so it never lingers a cycle after tx/rx ends
  wire to_txrx    = mode_d == can_mode_pkg::MODE_TXRX;
  wire in_sleep   = mode_q == can_mode_pkg::MODE_SLEEP;

  // enable only from recessive tx, so a wake from sleep starts recessive
  assign drv_en_d = (to_txrx && normal_mode_in) &&
                    (drv_en_q || tx_q);

  wire wake_hit;
  wake_if wk ();
  assign wk.bus_dom    = bus_dom_q;
  assign wk.arm        = in_sleep && wake_en_in;
  assign wk.single_sel = single_pulse_wake_select_in;
  assign wake_hit      = wk.wake;

  can_wake_detect #(.WIN_CYC(WIN_CYC)) u_wake (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .wk         (wk)
  );

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_q      <= can_mode_pkg::MODE_SLEEP;
      drv_en_q    <= 1'b0;
      slew_q      <= can_mode_pkg::SLEW_FAST;
      wake_flag_q <= 1'b0;
      int_q       <= 1'b0;
      wake_req_q  <= 1'b0;
    end else begin
      mode_q   <= mode_d;
      drv_en_q <= drv_en_d;
      // unused code loads fastest setting
      if (slew_wr_in) slew_q <= (slew_sel_in > can_mode_pkg::SLEW_SLOW) ?
                                  can_mode_pkg::SLEW_FAST : slew_sel_in;
      // set wins over clear
      wake_flag_q <= wake_hit | (wake_flag_q & ~wake_flag_clr_in);
      int_q       <= wake_hit;
      wake_req_q  <= wake_hit && low_power_mode_in;
    end
  end

  // ******************************
  // outputs
  // ******************************
  // receive-only leaves driver off and tx unused
  assign drv_en_out       = drv_en_q;
  assign drv_dominant_out = drv_en_q && !tx_q;
  assign rcv_en_out       = !in_sleep;
  assign rx_pin_out       = in_sleep ? 1'b1 : !bus_dom_q;
  assign split_en_out     = !in_sleep;
  assign term_gnd_out     = in_sleep;
  assign wake_rcv_en_out  = in_sleep && wake_en_in;
  assign slew_out         = slew_q;
  assign wake_flag_out    = wake_flag_q;
  assign int_pulse_out    = int_q;
  assign wake_req_out     = wake_req_q;
  assign mode_out         = mode_q;

  drv_rxonly_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    mode_q == can_mode_pkg::MODE_RXONLY |-> !drv_en_out) else $error("driver on rx-only");
  reg_needed_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !bus_reg_on_in |=> in_sleep) else $error("awake without regulator");
  drv_enable_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $rose(drv_en_out) |-> $past(tx_q)) else $error("driver enabled while dominant");
  tx_dominant_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    drv_en_out && !tx_q |-> drv_dominant_out) else $error("tx low not dominant");
  rx_report_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !in_sleep |-> rx_pin_out == !bus_dom_q) else $error("rx wrong level");
  sleep_split_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    in_sleep |-> !split_en_out && term_gnd_out && !drv_en_out) else $error("sleep outputs");
  wake_gate_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !wake_en_in [*2] |-> !wake_hit) else $error("wake while disabled");
  wake_flag_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    wake_hit |=> (wake_flag_out && int_pulse_out) ##1 (!int_pulse_out || wake_hit))
    else $error("wake flag or pulse missing");
  cov_txrx:   cover property (@(posedge ref_clk_in) drv_dominant_out);
  cov_wake:   cover property (@(posedge ref_clk_in) wake_req_out);
  cov_rxonly: cover property (@(posedge ref_clk_in) mode_q == can_mode_pkg::MODE_RXONLY);
endmodule
`default_nettype wire

/* File: bench/can_bus_model.sv */
`default_nettype none
// ****
// bus wire seen by the receivers
// ****
module can_bus_model (
  input  wire logic drv_en_in,
  input  wire logic drv_dominant_in,
  input  wire logic node_dom_in,
  output logic      bus_dom_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // any dominant driver wins; an idle bus reads recessive
  assign bus_dom_out = (drv_en_in & drv_dominant_in) | node_dom_in;
endmodule
`default_nettype wire

/* File: bench/can_mode_wake_bench.sv */
`default_nettype none
// ****
// mode and wake bench
// ****
module can_mode_wake_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WIN = 400;
  logic ref_clk_in = 1'b0, reset_in = 1'b1, normal_mode_in = 1'b0, low_power_mode_in = 1'b0;
  logic bus_reg_on_in = 1'b0, slew_wr_in = 1'b0, wake_en_in = 1'b0, tx_pin_in = 1'b1;
  logic single_pulse_wake_select_in = 1'b0, wake_flag_clr_in = 1'b0, node_dom = 1'b0;
  logic [1:0] mode_sel_in = 2'h0, slew_sel_in = 2'h0, slew_out, mode_out;
  logic bus_diff_dom_in, rx_pin_out, drv_en_out, drv_dominant_out, rcv_en_out;
  logic split_en_out, term_gnd_out, wake_rcv_en_out, wake_flag_out, int_pulse_out;
  logic wake_req_out;
  int miscompares = 0, samples_checked = 0, seed = 24, ints = 0, reqs = 0, cyc = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  can_mode_wake #(.WIN_CYC(WIN)) u_can_mode_wake (.ref_clk_in, .reset_in, .mode_sel_in,
    .normal_mode_in, .low_power_mode_in, .bus_reg_on_in, .slew_sel_in, .slew_wr_in,
    .wake_en_in, .single_pulse_wake_select_in, .wake_flag_clr_in, .tx_pin_in,
    .bus_diff_dom_in, .rx_pin_out, .drv_en_out, .drv_dominant_out, .rcv_en_out,
    .split_en_out, .term_gnd_out, .wake_rcv_en_out, .slew_out, .wake_flag_out,
    .int_pulse_out, .wake_req_out, .mode_out);
  can_bus_model u_can_bus_model (.drv_en_in(drv_en_out), .drv_dominant_in(drv_dominant_out),
    .node_dom_in(node_dom), .bus_dom_out(bus_diff_dom_in));
  task automatic conclude();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [1:0] seen, input logic [1:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, msg, seen, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // one node on the bus drives dominant, then releases
  task automatic pulse(input int dom, input int gap);
    node_dom = 1'b1;
    cyc_n(dom);
    node_dom = 1'b0;
    cyc_n(gap);
  endtask
  task automatic rearm();
    wake_flag_clr_in = 1'b1;
    cyc_n(1);
    wake_flag_clr_in = 1'b0;
    cyc_n(1);
    ints = 0;
    reqs = 0;
  endtask
  // a hang shows up as a cycle count far past the planned run
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (int_pulse_out === 1'b1) ints <= ints + 1;
    if (wake_req_out === 1'b1) reqs <= reqs + 1;
    if (cyc == 6000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    cyc_n(20);
    reset_in = 1'b0;
    cyc_n(2);
    check(mode_out, can_mode_pkg::MODE_SLEEP, "reset mode");
    check(rx_pin_out, 1'b1, "rx idle");
    check(split_en_out, 1'b0, "split sleep");
    check(term_gnd_out, 1'b1, "term sleep");
    check(slew_out, can_mode_pkg::SLEW_FAST, "slew reset");
    mode_sel_in = 2'h1;
    normal_mode_in = 1'b1;
    cyc_n(8);
    check(mode_out, can_mode_pkg::MODE_SLEEP, "no supply");
    bus_reg_on_in = 1'b1;
    cyc_n(8);
    check(mode_out, can_mode_pkg::MODE_TXRX, "txrx");
    check(drv_en_out, 1'b1, "drv on");
    check(rcv_en_out & split_en_out, 1'b1, "rcv split");
    for (int i = 0; i < 12; i++) begin
      // dominant stretches stay far below the controller's timeout
      tx_pin_in = 1'($random(seed));
      cyc_n(10);
      check(drv_dominant_out, !tx_pin_in, "drive");
      check(rx_pin_out, tx_pin_in, "rx echo");
    end
    mode_sel_in = 2'h0;
    tx_pin_in = 1'b0;
    cyc_n(8);
    check(drv_en_out | split_en_out, 1'b0, "sleep off");
    mode_sel_in = 2'h1;
    cyc_n(8);
    check(drv_en_out, 1'b0, "tx low hold");
    check(drv_dominant_out, 1'b0, "recessive back");
    tx_pin_in = 1'b1;
    cyc_n(8);
    check(drv_en_out, 1'b1, "tx high en");
    mode_sel_in = 2'h2;
    tx_pin_in = 1'b0;
    cyc_n(8);
    check(drv_en_out, 1'b0, "rxonly drv");
    check(rx_pin_out, 1'b1, "tx ignored");
    node_dom = 1'b1;
    cyc_n(8);
    check(rx_pin_out, 1'b0, "rx dominant");
    node_dom = 1'b0;
    tx_pin_in = 1'b1;
    for (int i = 3; i >= 0; i--) begin
      slew_sel_in = 2'(i);
      slew_wr_in = 1'b1;
      cyc_n(1);
      slew_wr_in = 1'b0;
      cyc_n(2);
      check(slew_out, (i == 3) ? can_mode_pkg::SLEW_FAST : 2'(i), "slew");
    end
    mode_sel_in = 2'h0;
    low_power_mode_in = 1'b1;
    wake_en_in = 1'b1;
    cyc_n(8);
    check(wake_rcv_en_out, 1'b1, "wake rcv");
    rearm();
    pulse(25, 10 + ($random(seed) & 15));
    pulse(10, 10);
    pulse(10, 10);
    pulse(25, 12);
    check(wake_flag_out, 1'b0, "short pulses");
    pulse(25, 12);
    check(wake_flag_out, 1'b1, "pattern wake");
    check(2'(ints) | 2'(reqs) << 1, 2'h3, "int and wake req");
    rearm();
    pulse(25, 10);
    pulse(25, WIN + 20);
    pulse(25, 12);
    check(wake_flag_out, 1'b0, "window expiry");
    pulse(25, 10 + ($random(seed) & 15));
    pulse(25, 12);
    check(wake_flag_out, 1'b1, "restart");
    wake_en_in = 1'b0;
    rearm();
    repeat (3) pulse(25, 12);
    check(wake_flag_out, 1'b0, "wake disabled");
    wake_en_in = 1'b1;
    single_pulse_wake_select_in = 1'b1;
    rearm();
    pulse(60, 12);
    check(wake_flag_out, 1'b0, "single short");
    pulse(85, 12);
    check(wake_flag_out, 1'b1, "single wake");
    check(2'(ints), 2'h1, "single int pulse");
    conclude();
  end
endmodule
`default_nettype wire
